//--- core/rsw_defs.vh
// constants for the receive status word and receiver control block
// assumes a byte-wide frame input stream on the single system clock
//
// Contract
// - status bits 31, 14, 9:8 and 0 always zero
// - bit 30 set when frame failed address filtering
// - bits 29:16 carry frame size in bytes
// - bit 15 is OR of bits 11, 7, 6 and 1
// - bit 13 set for broadcast destination
// - bit 12 set when length field disagrees with actual length
// - bit 11 set for frame under 64 bytes; runt status pushed only with pass-bad-frames, runt data always written to data FIFO
// - bit 10 set for multicast destination
// - bit 7 set above 1518 bytes; frame still received whole
// - bit 6 set on collision after collision window
// - bit 5 set when type field above 1500; never for runts under 14 bytes
// - bit 4 set when watchdog expires, between 2048 and 2560 bytes
// - bit 3 set if receive error input seen during frame
// - bit 2 set for 4 dribble bits MII or 3+ at 10M; not with late collision
// - bit 1 set on CRC mismatch or receive error during frame
// - with checksum enable, 4 checksum bytes follow payload in data FIFO
// - one halted pulse once receiver actually stops after enable cleared
// - error flag on data underrun, status underrun or status overrun
// - receiver keeps running after error flag
// - status pushed only after all frame data written
`ifndef RSW_DEFS_VH
`define RSW_DEFS_VH
`define RSW_BIT_FILT 30
`define RSW_LEN_HI 29
`define RSW_LEN_LO 16
`define RSW_BIT_ES 15
`define RSW_BIT_BCAST 13
`define RSW_BIT_LENERR 12
`define RSW_BIT_RUNT 11
`define RSW_BIT_MCAST 10
`define RSW_BIT_LONG 7
`define RSW_BIT_LATE 6
`define RSW_BIT_TYPE 5
`define RSW_BIT_WDOG 4
`define RSW_BIT_MIIERR 3
`define RSW_BIT_DRIB 2
`define RSW_BIT_CRC 1
`define RSW_RUNT_LEN 14'h0040
`define RSW_HDR_LEN 14'h000E
`define RSW_DA_LAST 14'h0006
`define RSW_TYPE_HI_POS 14'h000D
`define RSW_TYPE_LO_POS 14'h000E
`define RSW_MAX_LEN 14'h05EE
`define RSW_TYPE_MAX 16'h05DC
`define RSW_WDOG_LEN 14'h0800
`define RSW_CSUM_BYTES 3'h4
`define RSW_DRIB_MII 3'h4
`define RSW_DRIB_10M 3'h3
`endif

//--- core/rsw_fifo.v
// parameterised synchronous fifo with valid/ready on both sides
// assumes one clock; underflow and overflow attempts are simply refused
`timescale 1ns/100ps
module rsw_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst,
    // write side
    input wire i_wr_valid,
    input wire [WIDTH-1:0] i_wr_data,
    output wire o_wr_ready,
    // read side
    output wire o_rd_valid,
    output wire [WIDTH-1:0] o_rd_data,
    input wire i_rd_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_ff;
    reg [AW-1:0] rp_ff;
    reg [AW:0] cnt_ff;
    wire do_wr = i_wr_valid && o_wr_ready;
    wire do_rd = i_rd_ready && o_rd_valid;
    assign o_wr_ready = (cnt_ff != DEPTH[AW:0]);
    assign o_rd_valid = (cnt_ff != {(AW+1){1'b0}});
    assign o_rd_data = mem[rp_ff];
    always @(posedge i_ref_clk)
    begin
        if (do_wr)
            mem[wp_ff] <= i_wr_data;
    end
    always @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wp_ff <= {AW{1'b0}};
            rp_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
                wp_ff <= (wp_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_ff + 1'b1;
            if (do_rd)
                rp_ff <= (rp_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_ff + 1'b1;
            if (do_wr && !do_rd)
                cnt_ff <= cnt_ff + 1'b1;
            else if (do_rd && !do_wr)
                cnt_ff <= cnt_ff - 1'b1;
        end
    end
endmodule // rsw_fifo

//--- core/rsw_rx.v
// receive status word builder and receiver control
// frame bytes arrive on the system clock from the mac interface layer;
// pins from outside the clock domain pass a two-stage synchroniser
`timescale 1ns/100ps
`include "rsw_defs.vh"
module rsw_rx #(
    parameter DEPTH = 16,
    parameter AW = 4,
    parameter SDEPTH = 16,
    parameter SAW = 4
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst,
    // control
    input wire i_receiver_enable_bit,
    input wire i_pass_bad_frames,
    input wire i_receive_checksum_enable,
    input wire i_mii_mode,
    // frame byte stream from the mac interface layer
    input wire i_frm_valid,
    input wire i_frm_sof,
    input wire i_frm_eof,
    input wire [7:0] i_frm_byte,
    output reg o_frm_ready,
    // per-frame side information, valid with eof
    input wire i_filt_fail,
    input wire i_crc_bad,
    input wire [2:0] i_drib_bits,
    input wire [31:0] i_csum,
    // asynchronous line events
    input wire i_rx_er,
    input wire i_collision,
    // host side
    input wire i_data_rd,
    input wire i_stat_rd,
    output reg [7:0] o_data,
    output reg o_data_valid,
    output reg [31:0] o_status,
    output reg o_status_valid,
    output reg o_receive_error_flag,
    output reg o_receiver_halted_pulse,
    output reg o_receiver_running
);
    localparam ST_IDLE = 2'h0;
    localparam ST_FRAME = 2'h1;
    localparam ST_CSUM = 2'h2;
    localparam ST_PUSH = 2'h3;
    reg [1:0] st_ff;
    reg [1:0] nxt_st;
    reg er_s1_ff;
    reg er_s2_ff;
    reg col_s1_ff;
    reg col_s2_ff;
    reg [13:0] len_ff;
    reg [15:0] tlen_ff;
    reg bcast_ff;
    reg mcast_ff;
    reg mii_ff;
    reg late_ff;
    reg frame_ok_ff;
    reg [2:0] cs_idx_ff;
    reg [31:0] cs_ff;
    reg [31:0] sw_ff;
    reg enable_ff;
    wire d_wr_ready;
    wire d_rd_valid;
    wire s_wr_ready;
    wire s_rd_valid;
    wire [7:0] d_rd_data;
    wire [31:0] s_rd_data;
    reg d_wr_valid;
    reg [7:0] d_wr_data;
    wire in_frame = (st_ff == ST_FRAME);
    wire take = i_frm_valid && o_frm_ready;
    wire [13:0] len_now = len_ff + 14'h0001;
    // own count of the data fifo: the registered ready must drop in the same cycle the fifo becomes full
    reg [AW:0] docc_ff;
    reg [AW:0] nxt_docc;
    wire d_push = d_wr_valid && d_wr_ready;
    wire d_pop = i_data_rd && d_rd_valid;
    // a 14-byte frame ends on the low type byte, which is not yet in tlen_ff
    wire [15:0] tlen_now = (len_now == `RSW_TYPE_LO_POS) ? {tlen_ff[15:8], i_frm_byte} : tlen_ff;
    // two-flop synchronisers for line pins
    always @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            er_s1_ff <= 1'b0;
            er_s2_ff <= 1'b0;
            col_s1_ff <= 1'b0;
            col_s2_ff <= 1'b0;
        end
        else
        begin
            er_s1_ff <= i_rx_er;
            er_s2_ff <= er_s1_ff;
            col_s1_ff <= i_collision;
            col_s2_ff <= col_s1_ff;
        end
    end
    // status word assembly from the accumulated frame flags
    reg [31:0] sw_c;
    reg runt_c;
    reg long_c;
    reg wdog_c;
    reg lenerr_c;
    reg crc_c;
    reg drib_c;
    reg type_c;
    always @*
    begin
        runt_c = (len_now < `RSW_RUNT_LEN);
        long_c = (len_now > `RSW_MAX_LEN);
        wdog_c = (len_now > `RSW_WDOG_LEN);
        type_c = (len_now >= `RSW_HDR_LEN) && (tlen_now > `RSW_TYPE_MAX);
        lenerr_c = !type_c && (len_now >= `RSW_HDR_LEN) &&
            ({2'b00, len_now} != tlen_now + {2'b00, `RSW_HDR_LEN});
        crc_c = i_crc_bad || mii_ff;
        drib_c = !late_ff &&
            (i_mii_mode ? (i_drib_bits == `RSW_DRIB_MII) : (i_drib_bits >= `RSW_DRIB_10M));
        sw_c = 32'h00000000;
        sw_c[`RSW_BIT_FILT] = i_filt_fail;
        sw_c[`RSW_LEN_HI:`RSW_LEN_LO] = len_now;
        sw_c[`RSW_BIT_BCAST] = bcast_ff;
        sw_c[`RSW_BIT_LENERR] = lenerr_c;
        sw_c[`RSW_BIT_RUNT] = runt_c;
        sw_c[`RSW_BIT_MCAST] = mcast_ff;
        sw_c[`RSW_BIT_LONG] = long_c;
        sw_c[`RSW_BIT_LATE] = late_ff;
        sw_c[`RSW_BIT_TYPE] = type_c;
        sw_c[`RSW_BIT_WDOG] = wdog_c;
        sw_c[`RSW_BIT_MIIERR] = mii_ff;
        sw_c[`RSW_BIT_DRIB] = drib_c;
        sw_c[`RSW_BIT_CRC] = crc_c;
        sw_c[`RSW_BIT_ES] = runt_c | long_c | late_ff | crc_c;
    end
    // frame sequencer; the status push waits for the last data byte
    always @*
    begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE:
                if (take && i_frm_sof && enable_ff)
                    nxt_st = i_frm_eof ? (i_receive_checksum_enable ? ST_CSUM : ST_PUSH) : ST_FRAME;
            ST_FRAME:
                if (take && i_frm_eof)
                    nxt_st = i_receive_checksum_enable ? ST_CSUM : ST_PUSH;
            ST_CSUM:
                if (d_wr_ready && cs_idx_ff == `RSW_CSUM_BYTES - 3'h1)
                    nxt_st = ST_PUSH;
            ST_PUSH:
                nxt_st = ST_IDLE;
            default:
                nxt_st = ST_IDLE;
        endcase
    end
    always @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_ff <= ST_IDLE;
            len_ff <= 14'h0000;
            tlen_ff <= 16'h0000;
            docc_ff <= {(AW+1){1'b0}};
            bcast_ff <= 1'b0;
            mcast_ff <= 1'b0;
            mii_ff <= 1'b0;
            late_ff <= 1'b0;
            frame_ok_ff <= 1'b0;
            cs_idx_ff <= 3'h0;
            cs_ff <= 32'h00000000;
            sw_ff <= 32'h00000000;
            enable_ff <= 1'b0;
            o_receiver_halted_pulse <= 1'b0;
            o_receiver_running <= 1'b0;
            o_receive_error_flag <= 1'b0;
            o_frm_ready <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            docc_ff <= nxt_docc;
            o_frm_ready <= (nxt_st == ST_IDLE || nxt_st == ST_FRAME) && (nxt_docc != DEPTH[AW:0]);
            // enable only takes effect between frames, so halting lets the frame finish
            o_receiver_halted_pulse <= 1'b0;
            if (nxt_st == ST_IDLE)
            begin
                enable_ff <= i_receiver_enable_bit;
                if (enable_ff && !i_receiver_enable_bit)
                    o_receiver_halted_pulse <= 1'b1;
            end
            o_receiver_running <= enable_ff || st_ff != ST_IDLE;
            // error flag is sticky; reception continues regardless
            if ((i_data_rd && !d_rd_valid) || (i_stat_rd && !s_rd_valid) ||
                (st_ff == ST_PUSH && frame_ok_ff && !s_wr_ready))
                o_receive_error_flag <= 1'b1;
            if (st_ff == ST_IDLE && take && i_frm_sof && enable_ff)
            begin
                // fresh accumulators for the new frame
                // the start byte is the first counted byte; the push state left len_ff at zero
                len_ff <= len_now;
                bcast_ff <= (i_frm_byte == 8'hFF);
                mcast_ff <= i_frm_byte[0];
                mii_ff <= er_s2_ff;
                late_ff <= 1'b0;
                tlen_ff <= 16'h0000;
            end
            else if (in_frame && take)
            begin
                len_ff <= len_now;
                if (len_now <= `RSW_DA_LAST)
                    bcast_ff <= bcast_ff && (i_frm_byte == 8'hFF);
                if (len_now == `RSW_TYPE_HI_POS)
                    tlen_ff <= {i_frm_byte, 8'h00};
                if (len_now == `RSW_TYPE_LO_POS)
                    tlen_ff <= {tlen_ff[15:8], i_frm_byte};
            end
            // line events count even while the byte stream is stalled
            if (in_frame && er_s2_ff)
                mii_ff <= 1'b1;
            if (in_frame && col_s2_ff && len_now >= `RSW_RUNT_LEN)
                late_ff <= 1'b1;
            if ((st_ff == ST_FRAME || st_ff == ST_IDLE) && take && i_frm_eof)
            begin
                // runt status word dropped unless pass-bad-frames is set; its data bytes still go to the data fifo
                frame_ok_ff <= !(len_now < `RSW_RUNT_LEN) || i_pass_bad_frames;
                sw_ff <= sw_c;
                cs_ff <= i_csum;
                cs_idx_ff <= 3'h0;
            end
            if (st_ff == ST_CSUM && d_wr_ready)
            begin
                cs_idx_ff <= cs_idx_ff + 3'h1;
                cs_ff <= {8'h00, cs_ff[31:8]};
            end
            if (st_ff == ST_PUSH)
            begin
                // nothing of this frame may leak into the next one
                len_ff <= 14'h0000;
                tlen_ff <= 16'h0000;
                bcast_ff <= 1'b0;
                mcast_ff <= 1'b0;
                mii_ff <= 1'b0;
                late_ff <= 1'b0;
            end
        end
    end
    always @*
    begin
        nxt_docc = docc_ff;
        if (d_push && !d_pop)
            nxt_docc = docc_ff + {{AW{1'b0}}, 1'b1};
        else if (d_pop && !d_push)
            nxt_docc = docc_ff - {{AW{1'b0}}, 1'b1};
    end
    // data path into the data fifo: payload then optional checksum
    always @*
    begin
        d_wr_valid = 1'b0;
        d_wr_data = i_frm_byte;
        if (st_ff == ST_CSUM)
        begin
            d_wr_valid = 1'b1;
            d_wr_data = cs_ff[7:0];
        end
        else if (take && (in_frame || (st_ff == ST_IDLE && i_frm_sof && enable_ff)))
            d_wr_valid = 1'b1;
    end
    rsw_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_data (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_wr_valid(d_wr_valid),
        .i_wr_data(d_wr_data),
        .o_wr_ready(d_wr_ready),
        .o_rd_valid(d_rd_valid),
        .o_rd_data(d_rd_data),
        .i_rd_ready(i_data_rd)
    );
    // status word lands only after the frame's last data byte
    rsw_fifo #(.WIDTH(32), .DEPTH(SDEPTH), .AW(SAW)) u_stat (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_wr_valid(st_ff == ST_PUSH && frame_ok_ff),
        .i_wr_data(sw_ff),
        .o_wr_ready(s_wr_ready),
        .o_rd_valid(s_rd_valid),
        .o_rd_data(s_rd_data),
        .i_rd_ready(i_stat_rd)
    );
    // registered host outputs
    always @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_data <= 8'h00;
            o_data_valid <= 1'b0;
            o_status <= 32'h00000000;
            o_status_valid <= 1'b0;
        end
        else
        begin
            o_data_valid <= i_data_rd && d_rd_valid;
            if (i_data_rd && d_rd_valid)
                o_data <= d_rd_data;
            o_status_valid <= i_stat_rd && s_rd_valid;
            if (i_stat_rd && s_rd_valid)
                o_status <= s_rd_data;
        end
    end
endmodule // rsw_rx

//--- tb/rsw_rx_sva.sv
// checker for the receive status word and receiver control outputs
// assumes it is bound into rsw_rx, one clock, async active-high reset
`timescale 1ns/100ps
module rsw_rx_sva (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst,
    // watched ports
    input wire i_receiver_enable_bit,
    input wire [31:0] o_status,
    input wire o_status_valid,
    input wire o_receive_error_flag,
    input wire o_receiver_halted_pulse
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    wire [13:0] len = o_status[29:16];
    a_rsvd_zero: assert property (o_status_valid |-> {o_status[31], o_status[14], o_status[9:8], o_status[0]} == 5'h00)
        else $error("reserved status bit set");
    a_err_summary: assert property (o_status_valid |-> o_status[15] == |{o_status[11], o_status[7:6], o_status[1]})
        else $error("error summary wrong");
    a_runt_size: assert property (o_status_valid |-> o_status[11] == (len < 14'h0040))
        else $error("runt bit wrong");
    a_long_size: assert property (o_status_valid |-> o_status[7] == (len > 14'h05EE))
        else $error("too long bit wrong");
    a_type_short: assert property (o_status_valid && len < 14'h000E |-> !o_status[5])
        else $error("type bit on short runt");
    a_wdog_size: assert property (o_status_valid |-> o_status[4] == (len > 14'h0800))
        else $error("watchdog bit wrong");
    a_drib_late: assert property (o_status_valid && o_status[6] |-> !o_status[2])
        else $error("dribble with late collision");
    a_halt_single: assert property (o_receiver_halted_pulse |=> !o_receiver_halted_pulse)
        else $error("halted pulse too long");
    a_halt_cause: assert property (o_receiver_halted_pulse |-> $past(i_receiver_enable_bit) == 1'b0)
        else $error("halted pulse while enabled");
    a_err_sticky: assert property (o_receive_error_flag |=> o_receive_error_flag)
        else $error("error flag dropped");
    c_runt: cover property (o_status_valid && o_status[11]);
    c_halt: cover property (o_receiver_halted_pulse);
    c_err: cover property ($rose(o_receive_error_flag));
endmodule // rsw_rx_sva
bind rsw_rx rsw_rx_sva u_sva (.i_ref_clk, .i_rst, .i_receiver_enable_bit, .o_status, .o_status_valid,
    .o_receive_error_flag, .o_receiver_halted_pulse);

//--- tb/rsw_host.sv
// host model reading the receive status and data fifos
// assumes an answer one cycle after a one-cycle read pulse
`timescale 1ns/100ps
module rsw_host (
    // clock
    input wire i_ref_clk,
    // answers
    input wire [7:0] i_data,
    input wire i_data_valid,
    input wire [31:0] i_status,
    input wire i_status_valid,
    // read pulses
    output reg o_data_rd,
    output reg o_stat_rd
);
    initial
    begin
        o_data_rd = 1'b0;
        o_stat_rd = 1'b0;
    end
    // gap idles the host after each read so it can also read slowly
    task rd(input st, input integer gap, output [31:0] v, output ok);
        begin
            @(posedge i_ref_clk);
            o_stat_rd <= st;
            o_data_rd <= !st;
            @(posedge i_ref_clk);
            o_stat_rd <= 1'b0;
            o_data_rd <= 1'b0;
            #1;
            ok = st ? i_status_valid : i_data_valid;
            v = st ? i_status : {24'h000000, i_data};
            repeat (gap) @(posedge i_ref_clk);
        end
    endtask
endmodule // rsw_host

//--- tb/testbench.sv
// self-checking bench for rsw_rx with a host reading model
// assumes default fifo depths of 16
`timescale 1ns/100ps
module testbench;
    reg i_ref_clk, i_rst, i_receiver_enable_bit, i_pass_bad_frames, i_receive_checksum_enable, i_mii_mode;
    reg i_frm_valid, i_frm_sof, i_frm_eof, i_filt_fail, i_crc_bad, i_rx_er, i_collision;
    reg f_crc, f_ff, f_late, f_rxer, f_mii;
    reg [7:0] i_frm_byte;
    reg [2:0] i_drib_bits, f_db;
    reg [31:0] i_csum, v;
    reg ok;
    wire o_frm_ready, i_data_rd, i_stat_rd, o_data_valid, o_status_valid, o_receive_error_flag;
    wire o_receiver_halted_pulse, o_receiver_running;
    wire [7:0] o_data;
    wire [31:0] o_status;
    integer err_count, checked, f_gap, m;
    rsw_rx u_dut (.i_ref_clk, .i_rst, .i_receiver_enable_bit, .i_pass_bad_frames, .i_receive_checksum_enable,
        .i_mii_mode, .i_frm_valid, .i_frm_sof, .i_frm_eof, .i_frm_byte, .o_frm_ready, .i_filt_fail, .i_crc_bad,
        .i_drib_bits, .i_csum, .i_rx_er, .i_collision, .i_data_rd, .i_stat_rd, .o_data, .o_data_valid, .o_status,
        .o_status_valid, .o_receive_error_flag, .o_receiver_halted_pulse, .o_receiver_running);
    rsw_host u_host (.i_ref_clk, .i_data(o_data), .i_data_valid(o_data_valid), .i_status(o_status),
        .i_status_valid(o_status_valid), .o_data_rd(i_data_rd), .o_stat_rd(i_stat_rd));
    initial
    begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = !i_ref_clk;
    end
    task close_out;
        begin
            if (err_count == 0 && checked > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp)
            begin
                err_count = err_count + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task tmo;
        begin
            err_count = err_count + 1;
            close_out;
        end
    endtask
    function [7:0] bv(input integer k, input [7:0] b0, input [15:0] lt);
        bv = k < 6 ? b0 : k == 12 ? lt[15:8] : k == 13 ? lt[7:0] : k[7:0];
    endfunction
    function [31:0] expw(input integer n, input [7:0] b0, input [15:0] lt);
        begin
            expw = 32'h00000000;
            expw[30] = f_ff;
            expw[29:16] = n[13:0];
            expw[13] = b0 == 8'hFF;
            expw[12] = lt <= 16'h05DC && n != lt + 16'h000E;
            expw[11] = n < 'h40;
            expw[10] = b0[0];
            expw[7] = n > 'h5EE;
            expw[6] = f_late;
            expw[5] = lt > 16'h05DC && n >= 'hE;
            expw[4] = n > 'h800;
            expw[3] = f_rxer;
            expw[2] = !f_late && (f_mii ? f_db == 3'h4 : f_db >= 3'h3);
            expw[1] = f_crc | f_rxer;
            expw[15] = expw[11] | expw[7] | expw[6] | expw[1];
        end
    endfunction
    task send(input integer n, input [7:0] b0, input [15:0] lt);
        integer k, t;
        begin
            for (k = 0; k < n; k = k + 1)
            begin
                @(posedge i_ref_clk);
                {i_frm_valid, i_frm_sof, i_frm_eof} <= {1'b1, k == 0, k == n - 1};
                {i_filt_fail, i_crc_bad, i_drib_bits, i_mii_mode} <= {f_ff, f_crc, f_db, f_mii};
                i_frm_byte <= bv(k, b0, lt);
                i_collision <= f_late && k >= 66;
                i_rx_er <= f_rxer && k == 5;
                t = 0;
                @(negedge i_ref_clk);
                while (!o_frm_ready)
                begin
                    t = t + 1;
                    if (t > 200) tmo;
                    @(negedge i_ref_clk);
                end
            end
            @(posedge i_ref_clk);
            {i_frm_valid, i_frm_eof, i_collision} <= 3'h0;
        end
    endtask
    task drain(input integer n, input [7:0] b0, input [15:0] lt);
        integer k;
        begin
            repeat (8) @(posedge i_ref_clk);
            for (k = 0; k < n + (i_receive_checksum_enable ? 4 : 0); k = k + 1)
            begin
                u_host.rd(1'b0, f_gap, v, ok);
                chk(ok, 1'b1);
                chk(v, k < n ? bv(k, b0, lt) : i_csum >> 8 * (k - n) & 32'hFF);
            end
        end
    endtask
    task stat(input [31:0] e);
        begin
            repeat (4) @(posedge i_ref_clk);
            u_host.rd(1'b1, 0, v, ok);
            chk({ok, v}, {1'b1, e});
        end
    endtask
    // md 0: data then status, 1: status first, 2: no status read
    task frame(input integer n, input [7:0] b0, input [15:0] lt, input integer md);
        begin
            if (md == 1)
            begin
                send(n, b0, lt);
                stat(expw(n, b0, lt));
                drain(n, b0, lt);
            end
            else
            begin
                fork
                    send(n, b0, lt);
                    drain(n, b0, lt);
                join
                if (md == 0 && (n >= 64 || i_pass_bad_frames))
                    stat(expw(n, b0, lt));
            end
        end
    endtask
    task do_reset;
        begin
            @(posedge i_ref_clk);
            i_rst <= 1'b1;
            repeat (3) @(posedge i_ref_clk);
            i_rst <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
            chk(o_receive_error_flag, 1'b0);
        end
    endtask
    task sc_class;
        begin
            f_ff = 1'b1;
            frame(64, 8'hFF, 16'h0800, 0);
            f_ff = 1'b0;
            frame(70, 8'h01, 16'h0038, 0);
            frame(65, 8'h02, 16'h0010, 0);
            f_gap = 1;
            frame(1519, 8'h00, 16'h0800, 0);
            frame(2049, 8'h00, 16'h0800, 0);
            f_gap = 0;
        end
    endtask
    task sc_err;
        begin
            f_crc = 1'b1;
            frame(64, 8'h00, 16'h0800, 0);
            {f_crc, f_rxer} = 2'h1;
            frame(64, 8'h00, 16'h0800, 0);
            f_rxer = 1'b0;
            for (m = 0; m < 6; m = m + 1)
            begin
                f_mii = m / 3;
                f_db = 3'h2 + m % 3;
                frame(64, 8'h00, 16'h0800, 0);
            end
            {f_mii, f_late} = 2'h3;
            frame(80, 8'h00, 16'h0800, 0);
            {f_late, f_db} = 4'h0;
        end
    endtask
    task sc_runt;
        begin
            frame(20, 8'h00, 16'h0800, 0);
            frame(64, 8'h00, 16'h0800, 0);
            i_pass_bad_frames <= 1'b1;
            frame(13, 8'h00, 16'h0800, 1);
            i_pass_bad_frames <= 1'b0;
            i_receive_checksum_enable <= 1'b1;
            frame(64, 8'h00, 16'h0800, 0);
            i_receive_checksum_enable <= 1'b0;
        end
    endtask
    task sc_halt;
        integer p;
        begin
            @(posedge i_ref_clk);
            i_receiver_enable_bit <= 1'b0;
            p = 0;
            repeat (30)
            begin
                @(negedge i_ref_clk);
                p = p + o_receiver_halted_pulse;
            end
            chk(p, 1);
            chk(o_receiver_running, 1'b0);
            i_receiver_enable_bit <= 1'b1;
            p = 0;
            while (o_receiver_running !== 1'b1)
            begin
                p = p + 1;
                if (p > 50) tmo;
                @(negedge i_ref_clk);
            end
            frame(64, 8'h00, 16'h0800, 0);
        end
    endtask
    task sc_fault;
        begin
            u_host.rd(1'b1, 2, v, ok);
            chk({ok, o_receive_error_flag}, 2'h1);
            frame(64, 8'h00, 16'h0800, 0);
            do_reset;
            u_host.rd(1'b0, 2, v, ok);
            chk({ok, o_receive_error_flag}, 2'h1);
            do_reset;
            i_pass_bad_frames <= 1'b1;
            repeat (17) frame(14, 8'h00, 16'h0800, 2);
            chk(o_receive_error_flag, 1'b1);
            do_reset;
        end
    endtask
    initial
    begin
        {err_count, checked, f_gap} = 0;
        {i_rst, i_receiver_enable_bit, i_mii_mode, f_mii} = 4'hF;
        {i_pass_bad_frames, i_receive_checksum_enable, i_frm_valid, i_frm_sof, i_frm_eof} = 5'h00;
        {i_filt_fail, i_crc_bad, i_rx_er, i_collision, f_crc, f_ff, f_late, f_rxer} = 8'h00;
        {i_frm_byte, i_drib_bits, f_db} = 14'h0000;
        i_csum = 32'hA1B2C3D4;
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        sc_class;
        sc_err;
        sc_runt;
        sc_halt;
        sc_fault;
        close_out;
    end
endmodule // testbench
